// ===== pkg/pp_mem_if.sv
// Link between the port control and the memory arrays.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface pp_mem_if;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic fl_latch;
    logic ee_latch;
    logic fl_prog;
    logic ee_prog;
    logic erase_start;
    logic erase_ee;
    logic buf_clear;
    logic erase_done;
    logic [15:0] fl_rdata;
    logic [7:0] ee_rdata;
    modport ctl(output addr, wdata, fl_latch, ee_latch, fl_prog, ee_prog, erase_start, erase_ee, buf_clear,
                input erase_done, fl_rdata, ee_rdata);
    modport mem(input addr, wdata, fl_latch, ee_latch, fl_prog, ee_prog, erase_start, erase_ee, buf_clear,
                output erase_done, fl_rdata, ee_rdata);
endinterface

// ===== pkg/pp_pkg.sv
// Types of the parallel programming port.
// Assumes nothing beyond the compiler.
package pp_pkg;
    typedef enum logic [2:0] {ENT_OUT, ENT_ARMED, ENT_SETTLE, ENT_PROG, ENT_FAIL} pp_entry_type;
    typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} pp_op_type;
endpackage

// ===== pkg/pp_regs.svh
// Constants of the parallel programming port: timing, commands, offsets.
// Assumes a 25 ns pclk; included by bare name.
`ifndef PP_REGS_SVH
`define PP_REGS_SVH

// ==========================================
// Timing
`define PP_CLK_NS 25
`define PP_T_ENTRY_NS 100
`define PP_T_PROG_NS 3700000
`define PP_T_ERASE_NS 7500000
`define PP_ENTRY_CYC ((`PP_T_ENTRY_NS + `PP_CLK_NS - 1) / `PP_CLK_NS)

// ==========================================
// Commands and strobe actions
`define PP_CMD_NOP 8'h00
`define PP_CMD_ERASE 8'h80
`define PP_CMD_WFUSE 8'h40
`define PP_CMD_WLOCK 8'h20
`define PP_CMD_WFLASH 8'h10
`define PP_CMD_WEE 8'h11
`define PP_CMD_RFUSE 8'h04
`define PP_CMD_RFLASH 8'h02
`define PP_CMD_REE 8'h03
`define PP_ACT_ADDR 2'h0
`define PP_ACT_DATA 2'h1
`define PP_ACT_CMD 2'h2

// ==========================================
// Geometry
`define PP_FL_ADDR_BITS 13
`define PP_FL_WORD_BITS 6
`define PP_EE_ADDR_BITS 9
`define PP_EE_WORD_BITS 2

// ==========================================
// Nonvolatile reset and erased values
`define PP_FUSE_LO_RST 8'hE1
`define PP_FUSE_HI_RST 8'hFF
`define PP_LOCK_RST 8'hFF
`define PP_FH_EEPROM_PRESERVE_FUSE_BIT 3
`define PP_FL_ERASED 16'hFFFF
`define PP_EE_ERASED 8'hFF
`define PP_IDLE_BYTE 8'hFF

// ==========================================
// APB map
`define PP_OFS_CTRL 8'h00
`define PP_OFS_STATUS 8'h04
`define PP_OFS_ADDR 8'h08
`define PP_CTRL_EN_BIT 0
`define PP_CTRL_RST 1'h1

`endif

// ===== sim/parallel_memory_programmer_tb_top.sv
// Self-checking bench of the parallel programming port.
// Assumes pp_pgm_model on the pins and APB on the status side.
`timescale 1ns/1ps
`include "pp_regs.svh"
module parallel_memory_programmer_tb_top;
    localparam logic [1:0] A = `PP_ACT_ADDR;
    localparam logic [1:0] D = `PP_ACT_DATA;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic pready, pslverr, e, ls, ash, asl, bs1, bs2, pl, wr_n, oe_n, hv, doe, rdy, lo, hi;
    logic [7:0] pgm_d, bus, dout, v;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    assign bus = doe ? dout : pgm_d;
    pp_prog_port #(.T_PROG_CYC(20), .T_ERASE_CYC(40)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .load_strobe(ls), .action_sel_hi(ash), .action_sel_lo(asl), .byte_sel_first(bs1),
        .byte_sel_second(bs2), .page_latch_strobe(pl), .write_n(wr_n), .out_en_n(oe_n), .hv_reset(hv),
        .data_in(bus), .data_out(dout), .data_oe(doe), .ready_flag(rdy));
    pp_pgm_model pgm (.pclk(pclk), .load_strobe(ls), .action_sel_hi(ash), .action_sel_lo(asl),
        .byte_sel_first(bs1), .byte_sel_second(bs2), .page_latch_strobe(pl), .write_n(wr_n), .out_en_n(oe_n),
        .hv_reset(hv), .data_in(pgm_d), .data_out(dout), .data_oe(doe), .ready_flag(rdy));
    task automatic summarize();
        $display("checks=%0d bad=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c);
        pgm.load(`PP_ACT_CMD, 1'b0, c);
    endtask
    task automatic wchk(input logic b2, input logic b1);
        pgm.wr(b2, b1, lo, hi);
        chk({lo, hi}, 2'h3);
    endtask
    task automatic rchk(input logic b2, input logic b1, input logic [7:0] x);
        pgm.rd(b2, b1, v);
        chk(v, x);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk({rdy, doe}, 2'h2);
        apb(1'b0, `PP_OFS_CTRL, 32'h0);
        chk(r[0], `PP_CTRL_RST);
        apb(1'b0, 8'h0C, 32'h0);
        chk(r, 32'h0);
        chk(e, 1'b1);
        pgm.enter(1'b1);
        apb(1'b0, `PP_OFS_STATUS, 32'h0);
        chk(r[2:0], 3'h6);
        apb(1'b1, `PP_OFS_CTRL, 32'h0);
        pgm.enter(1'b0);
        apb(1'b0, `PP_OFS_STATUS, 32'h0);
        chk(r[2:0], 3'h2);
        apb(1'b1, `PP_OFS_CTRL, 32'h1);
        pgm.hold(8);
        apb(1'b0, `PP_OFS_STATUS, 32'h0);
        chk(r[2:0], 3'h3);
        $display("test entry done");
        cmd(`PP_CMD_ERASE);
        wchk(1'b0, 1'b0);
        cmd(`PP_CMD_WFLASH);
        pgm.load(A, 1'b0, 8'h41);
        pgm.load(D, 1'b0, 8'hA5);
        pgm.load(D, 1'b1, 8'h3C);
        pgm.latch();
        pgm.load(A, 1'b1, 8'h00);
        wchk(1'b0, 1'b0);
        cmd(`PP_CMD_NOP);
        cmd(`PP_CMD_RFLASH);
        rchk(1'b0, 1'b0, 8'hA5);
        rchk(1'b0, 1'b1, 8'h3C);
        pgm.load(A, 1'b0, 8'h01);
        rchk(1'b0, 1'b0, 8'hFF);
        chk(doe, 1'b0);
        $display("test flash done");
        cmd(`PP_CMD_WEE);
        pgm.load(A, 1'b0, 8'h06);
        pgm.load(D, 1'b0, 8'h77);
        pgm.latch();
        cmd(`PP_CMD_NOP);
        cmd(`PP_CMD_WEE);
        pgm.load(A, 1'b0, 8'h05);
        pgm.load(D, 1'b0, 8'h5A);
        pgm.latch();
        wchk(1'b0, 1'b0);
        cmd(`PP_CMD_WFUSE);
        pgm.load(D, 1'b0, 8'hF7);
        wchk(1'b0, 1'b1);
        cmd(`PP_CMD_WLOCK);
        pgm.load(D, 1'b0, 8'hFC);
        wchk(1'b0, 1'b0);
        cmd(`PP_CMD_RFUSE);
        rchk(1'b0, 1'b0, `PP_FUSE_LO_RST);
        rchk(1'b1, 1'b1, 8'hF7);
        rchk(1'b0, 1'b1, 8'hFC);
        $display("test fuse done");
        cmd(`PP_CMD_ERASE);
        wchk(1'b0, 1'b0);
        cmd(`PP_CMD_RFUSE);
        rchk(1'b0, 1'b1, 8'hFF);
        rchk(1'b1, 1'b1, 8'hF7);
        cmd(`PP_CMD_REE);
        pgm.load(A, 1'b0, 8'h05);
        rchk(1'b0, 1'b0, 8'h5A);
        pgm.load(A, 1'b0, 8'h06);
        rchk(1'b0, 1'b0, 8'hFF);
        cmd(`PP_CMD_RFLASH);
        pgm.load(A, 1'b0, 8'h41);
        rchk(1'b0, 1'b1, 8'hFF);
        $display("test erase done");
        summarize();
    end
endmodule // parallel_memory_programmer_tb_top

// ===== sim/pp_pgm_model.sv
// Programmer model: drives the programming pins, samples ready and data.
// Assumes pins change just after pclk rises and hold 6 cycles around strobes.
`timescale 1ns/1ps
module pp_pgm_model (
    input wire logic pclk,
    output logic load_strobe,
    output logic action_sel_hi,
    output logic action_sel_lo,
    output logic byte_sel_first,
    output logic byte_sel_second,
    output logic page_latch_strobe,
    output logic write_n,
    output logic out_en_n,
    output logic hv_reset,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic ready_flag
);
    initial begin
        {load_strobe, action_sel_hi, action_sel_lo, byte_sel_first} = 4'h0;
        {byte_sel_second, page_latch_strobe, hv_reset} = 3'h0;
        {write_n, out_en_n} = 2'h3;
        data_in = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Bump on an entry pin just after high voltage
    task automatic enter(input logic bump);
        hv_reset <= 1'b0;
        repeat (6) begin
            hold(6);
            load_strobe <= ~load_strobe;
        end
        hold(6);
        hv_reset <= 1'b1;
        hold(1);
        action_sel_lo <= bump;
        hold(10);
        action_sel_lo <= 1'b0;
        hold(6);
    endtask
    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
        {action_sel_hi, action_sel_lo} <= act;
        byte_sel_first <= bs1;
        data_in <= val;
        hold(6);
        load_strobe <= 1'b1;
        hold(6);
        load_strobe <= 1'b0;
        hold(6);
    endtask
    task automatic latch();
        byte_sel_first <= 1'b1;
        hold(6);
        page_latch_strobe <= 1'b1;
        hold(6);
        page_latch_strobe <= 1'b0;
        hold(6);
    endtask
    // Waits for ready under a bound; reports both edges of the busy period
    task automatic wr(input logic bs2, input logic bs1, output logic lo, output logic hi);
        {byte_sel_second, byte_sel_first} <= {bs2, bs1};
        hold(6);
        write_n <= 1'b0;
        hold(6);
        write_n <= 1'b1;
        @(negedge pclk);
        lo = (ready_flag === 1'b0);
        hi = 1'b0;
        for (int i = 0; i < 20000 && !hi; i++) begin
            @(negedge pclk);
            hi = (ready_flag === 1'b1);
        end
        hold(1);
    endtask
    // Bus released while reading: drive the inverse of the last value
    task automatic rd(input logic bs2, input logic bs1, output logic [7:0] val);
        {byte_sel_second, byte_sel_first} <= {bs2, bs1};
        data_in <= ~data_in;
        out_en_n <= 1'b0;
        hold(6);
        @(negedge pclk);
        val = data_oe ? data_out : 8'hXX;
        @(posedge pclk);
        out_en_n <= 1'b1;
        hold(6);
    endtask
endmodule // pp_pgm_model

// ===== src/pp_nvm_array.sv
// Flash, EEPROM, page buffers and the chip erase sweep.
// Assumes controls are one-cycle pulses from the port control.
`timescale 1ns/1ps
`include "pp_regs.svh"
module pp_nvm_array #(
    parameter int FA = `PP_FL_ADDR_BITS,
    parameter int FW = `PP_FL_WORD_BITS,
    parameter int EA = `PP_EE_ADDR_BITS,
    parameter int EW = `PP_EE_WORD_BITS
) (
    input wire logic pclk,
    input wire logic presetn,
    pp_mem_if.mem m
);
    import pp_pkg::*;
    logic [15:0] fl_mem [2**FA];
    logic [7:0] ee_mem [2**EA];
    logic [15:0] fl_buf [2**FW];
    logic [7:0] ee_buf [2**EW];
    logic er_act_q;
    logic er_ee_q;
    logic done_q;
    logic [FA-1:0] er_cnt_q;

    assign m.fl_rdata = fl_mem[m.addr[FA-1:0]];
    assign m.ee_rdata = ee_mem[m.addr[EA-1:0]];
    assign m.erase_done = done_q;

    // ==========================================
    // Erase sweep, one word per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            er_act_q <= 1'b0;
            er_ee_q <= 1'b0;
            done_q <= 1'b0;
            er_cnt_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (m.erase_start) begin
                er_act_q <= 1'b1;
                er_ee_q <= m.erase_ee;
                er_cnt_q <= '0;
            end else if (er_act_q) begin
                er_cnt_q <= er_cnt_q + 1'b1;
                if (&er_cnt_q) begin
                    er_act_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // Arrays
    always_ff @(posedge pclk) begin
        if (er_act_q) begin
            fl_mem[er_cnt_q] <= `PP_FL_ERASED;
        end else if (m.fl_prog) begin
            for (int i = 0; i < 2**FW; i++) begin
                fl_mem[{m.addr[FA-1:FW], FW'(i)}] <= fl_buf[i];
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (er_act_q && er_ee_q && (er_cnt_q >> EA) == '0) begin
            ee_mem[er_cnt_q[EA-1:0]] <= `PP_EE_ERASED;
        end else if (m.ee_prog) begin
            for (int i = 0; i < 2**EW; i++) begin
                ee_mem[{m.addr[EA-1:EW], EW'(i)}] <= ee_buf[i];
            end
        end
    end

    // ==========================================
    // Page buffers, blank after use or no-op
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2**FW; i++) fl_buf[i] <= `PP_FL_ERASED;
            for (int i = 0; i < 2**EW; i++) ee_buf[i] <= `PP_EE_ERASED;
        end else begin
            if (m.buf_clear || m.fl_prog) begin
                for (int i = 0; i < 2**FW; i++) fl_buf[i] <= `PP_FL_ERASED;
            end else if (m.fl_latch) begin
                fl_buf[m.addr[FW-1:0]] <= m.wdata;
            end
            if (m.buf_clear || m.ee_prog) begin
                for (int i = 0; i < 2**EW; i++) ee_buf[i] <= `PP_EE_ERASED;
            end else if (m.ee_latch) begin
                ee_buf[m.addr[EW-1:0]] <= m.wdata[7:0];
            end
        end
    end
endmodule // pp_nvm_array

// ===== src/pp_prog_port.sv
// Parallel programming port: entry, command and address loading, page
// writes, erase, fuse and lock handling, read-out and an APB status port.
// Assumes all pins are asynchronous to pclk and slower than 4 cycles.
//
// Contract
// - Entry pins moving in 100 ns abort
// - Command and address retained between accesses
// - Erase clears memories, locks last, keeps fuses
// - Preserve fuse keeps EEPROM through erase
// - Action 10 strobe loads command
// - Erase command plus write drops ready
// - Command 10h selects flash writing
// - Action 00 loads address low/high
// - Action 01 loads data low/high
// - Page latch stores data word
// - Low bits word, high bits page
// - Write pulse programs page, ready low
// - No-op command resets write controls
// - Command 11h selects EEPROM page writes
// - Flash read low/high byte
// - EEPROM read byte
// - Fuse write by byte selects
// - Lock bits only programmed, erase clears
// - Fuse and lock read by selects
// - Ready low while busy, high otherwise
// - Data driven only while output enable low
`timescale 1ns/1ps
`include "pp_regs.svh"
module pp_prog_port #(
    parameter int FA = `PP_FL_ADDR_BITS,
    parameter int FW = `PP_FL_WORD_BITS,
    parameter int EA = `PP_EE_ADDR_BITS,
    parameter int EW = `PP_EE_WORD_BITS,
    parameter int unsigned T_PROG_CYC = `PP_T_PROG_NS / `PP_CLK_NS,
    parameter int unsigned T_ERASE_CYC = `PP_T_ERASE_NS / `PP_CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic load_strobe,
    input wire logic action_sel_hi,
    input wire logic action_sel_lo,
    input wire logic byte_sel_first,
    input wire logic byte_sel_second,
    input wire logic page_latch_strobe,
    input wire logic write_n,
    input wire logic out_en_n,
    input wire logic hv_reset,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic ready_flag
);
    import pp_pkg::*;

    localparam int NS = 17;
    localparam logic [3:0] ENTRY_CYC = 4'(`PP_ENTRY_CYC);

    function automatic logic pp_rise(input logic [NS-1:0] now, input logic [NS-1:0] old, input int i);
        return now[i] & ~old[i];
    endfunction

    // ==========================================
    // Pin synchronisers
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    logic [NS-1:0] s3_q;
    assign pin_raw = {data_in, hv_reset, out_en_n, write_n, page_latch_strobe, byte_sel_second,
                      byte_sel_first, action_sel_lo, action_sel_hi, load_strobe};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic [1:0] act;
    logic bs1;
    logic bs2;
    logic hv;
    logic [7:0] din;
    logic [3:0] pe;
    assign act = {s2_q[1], s2_q[2]};
    assign bs1 = s2_q[3];
    assign bs2 = s2_q[4];
    assign hv = s2_q[8];
    assign din = s2_q[16:9];
    assign pe = {s2_q[5], s2_q[1], s2_q[2], s2_q[3]};

    // ==========================================
    // Programming mode entry
    pp_entry_type ent_q;
    logic [3:0] ent_cnt_q;
    logic ctrl_en_q;
    logic prog;
    assign prog = (ent_q == ENT_PROG);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ent_q <= ENT_OUT;
            ent_cnt_q <= '0;
        end else begin
            case (ent_q)
                ENT_OUT: begin
                    if (!hv && pe == '0) ent_q <= ENT_ARMED;
                end
                ENT_ARMED: begin
                    if (pe != '0) begin
                        ent_q <= ENT_OUT;
                    end else if (hv && ctrl_en_q) begin
                        ent_q <= ENT_SETTLE;
                        ent_cnt_q <= '0;
                    end
                end
                ENT_SETTLE: begin
                    if (!hv) begin
                        ent_q <= ENT_OUT;
                    end else if (pe != '0) begin
                        ent_q <= ENT_FAIL;
                    end else if (ent_cnt_q == ENTRY_CYC - 4'h1) begin
                        ent_q <= ENT_PROG;
                    end else begin
                        ent_cnt_q <= ent_cnt_q + 4'h1;
                    end
                end
                ENT_PROG, ENT_FAIL: begin
                    if (!hv) ent_q <= ENT_OUT;
                end
                default: ent_q <= ENT_OUT;
            endcase
        end
    end

    // ==========================================
    // Command, address and data loading
    pp_op_type op_q;
    logic [7:0] cmd_q;
    logic [15:0] addr_q;
    logic [15:0] data_q;
    logic ld;
    logic ld_cmd;
    logic pl;
    logic wr;
    assign ld = prog && pp_rise(s2_q, s3_q, 0);
    assign ld_cmd = ld && act == `PP_ACT_CMD && op_q == OP_IDLE;
    assign pl = prog && pp_rise(s2_q, s3_q, 5);
    assign wr = prog && pp_rise(s3_q, s2_q, 6) && op_q == OP_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= `PP_CMD_NOP;
        end else if (ld_cmd) begin
            cmd_q <= din;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= '0;
            data_q <= '0;
        end else if (ld && act == `PP_ACT_ADDR) begin
            if (bs1) addr_q[15:8] <= din;
            else addr_q[7:0] <= din;
        end else if (ld && act == `PP_ACT_DATA) begin
            if (bs1) data_q[15:8] <= din;
            else data_q[7:0] <= din;
        end
    end

    // ==========================================
    // Write pulse dispatch
    logic is_erase;
    logic is_wfl;
    logic is_wee;
    logic is_fuse;
    logic is_lock;
    logic wr_go;
    assign is_erase = cmd_q == `PP_CMD_ERASE;
    assign is_wfl = cmd_q == `PP_CMD_WFLASH && !bs1;
    assign is_wee = cmd_q == `PP_CMD_WEE && !bs1;
    assign is_fuse = cmd_q == `PP_CMD_WFUSE && !bs2;
    assign is_lock = cmd_q == `PP_CMD_WLOCK;
    assign wr_go = wr && (is_erase || is_wfl || is_wee || is_fuse || is_lock);

    logic [23:0] tmr_q;
    logic er_seen_q;
    logic ready_q;
    logic erase_done;
    logic [7:0] fuse_lo_q;
    logic [7:0] fuse_hi_q;
    logic [7:0] lock_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= OP_IDLE;
            tmr_q <= '0;
            er_seen_q <= 1'b0;
            ready_q <= 1'b1;
        end else begin
            case (op_q)
                OP_IDLE: begin
                    if (wr_go) begin
                        ready_q <= 1'b0;
                        er_seen_q <= 1'b0;
                        op_q <= is_erase ? OP_ERASE : OP_PROG;
                        tmr_q <= is_erase ? 24'(T_ERASE_CYC - 1) : 24'(T_PROG_CYC - 1);
                    end
                end
                OP_PROG: begin
                    if (tmr_q == '0) begin
                        op_q <= OP_IDLE;
                        ready_q <= 1'b1;
                    end else begin
                        tmr_q <= tmr_q - 24'h1;
                    end
                end
                OP_ERASE: begin
                    if (erase_done) er_seen_q <= 1'b1;
                    if (tmr_q != '0) tmr_q <= tmr_q - 24'h1;
                    if (tmr_q == '0 && (er_seen_q || erase_done)) begin
                        op_q <= OP_IDLE;
                        ready_q <= 1'b1;
                    end
                end
                default: op_q <= OP_IDLE;
            endcase
        end
    end

    // ==========================================
    // Fuses and lock bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_lo_q <= `PP_FUSE_LO_RST;
            fuse_hi_q <= `PP_FUSE_HI_RST;
            lock_q <= `PP_LOCK_RST;
        end else begin
            if (erase_done) begin
                lock_q <= `PP_LOCK_RST;
            end else if (wr_go && is_lock) begin
                lock_q <= lock_q & data_q[7:0];
            end
            if (wr_go && is_fuse) begin
                if (bs1) fuse_hi_q <= data_q[7:0];
                else fuse_lo_q <= data_q[7:0];
            end
        end
    end

    // ==========================================
    // Memory arrays
    pp_mem_if mem_bus();
    assign mem_bus.addr = addr_q;
    assign mem_bus.wdata = data_q;
    assign mem_bus.fl_latch = pl && bs1 && cmd_q == `PP_CMD_WFLASH;
    assign mem_bus.ee_latch = pl && cmd_q == `PP_CMD_WEE;
    assign mem_bus.fl_prog = wr_go && is_wfl;
    assign mem_bus.ee_prog = wr_go && is_wee;
    assign mem_bus.erase_start = wr_go && is_erase;
    assign mem_bus.erase_ee = fuse_hi_q[`PP_FH_EEPROM_PRESERVE_FUSE_BIT];
    assign mem_bus.buf_clear = ld_cmd && din == `PP_CMD_NOP;
    assign erase_done = mem_bus.erase_done;

    pp_nvm_array #(.FA(FA), .FW(FW), .EA(EA), .EW(EW)) u_array (
        .pclk(pclk),
        .presetn(presetn),
        .m(mem_bus.mem)
    );

    // ==========================================
    // Read-out
    logic oe_req;
    logic [7:0] rd_byte;
    logic [7:0] data_out_q;
    logic data_oe_q;
    assign oe_req = prog && !s2_q[7];

    always_comb begin
        rd_byte = `PP_IDLE_BYTE;
        case (cmd_q)
            `PP_CMD_RFLASH: rd_byte = bs1 ? mem_bus.fl_rdata[15:8] : mem_bus.fl_rdata[7:0];
            `PP_CMD_REE: rd_byte = mem_bus.ee_rdata;
            `PP_CMD_RFUSE: begin
                case ({bs2, bs1})
                    2'b00: rd_byte = fuse_lo_q;
                    2'b11: rd_byte = fuse_hi_q;
                    2'b01: rd_byte = lock_q;
                    default: rd_byte = `PP_IDLE_BYTE;
                endcase
            end
            default: rd_byte = `PP_IDLE_BYTE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out_q <= '0;
            data_oe_q <= 1'b0;
        end else begin
            data_oe_q <= oe_req;
            data_out_q <= oe_req ? rd_byte : 8'h00;
        end
    end

    // ==========================================
    // APB slave
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] rd_word;
    logic mapped;

    always_comb begin
        mapped = 1'b1;
        rd_word = '0;
        case (paddr)
            `PP_OFS_CTRL: rd_word = {31'h0, ctrl_en_q};
            `PP_OFS_STATUS: rd_word = {16'h0, cmd_q, 4'h0, op_q == OP_ERASE, ent_q == ENT_FAIL, ready_q, prog};
            `PP_OFS_ADDR: rd_word = {16'h0, addr_q};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q) begin
                prdata_q <= pwrite ? 32'h0 : rd_word;
                pslverr_q <= !mapped;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_q <= `PP_CTRL_RST;
        end else if (psel && penable && pready_q && pwrite && paddr == `PP_OFS_CTRL) begin
            ctrl_en_q <= pwdata[`PP_CTRL_EN_BIT];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign ready_flag = ready_q;

    // ==========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr_go;
        wr_go;
    endsequence
    sequence s_pin_move;
        ent_q == ENT_SETTLE && hv && pe != '0;
    endsequence

    property p_busy;
        s_wr_go |=> !ready_flag ##1 !ready_flag;
    endproperty
    a_busy: assert property (p_busy) else $error("ready stayed high after write pulse");

    property p_erase;
        s_wr_go ##0 is_erase |=> op_q == OP_ERASE && !ready_flag;
    endproperty
    a_erase: assert property (p_erase) else $error("erase did not start");

    property p_cmd;
        ld_cmd |=> cmd_q == $past(din);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not loaded");

    property p_keep;
        !ld |=> $stable(cmd_q) && $stable(addr_q);
    endproperty
    a_keep: assert property (p_keep) else $error("command or address lost");

    property p_addr;
        ld && act == `PP_ACT_ADDR && !bs1 |=> addr_q[7:0] == $past(din) && $stable(addr_q[15:8]);
    endproperty
    a_addr: assert property (p_addr) else $error("address low byte not loaded");

    property p_data;
        ld && act == `PP_ACT_DATA && bs1 |=> data_q[15:8] == $past(din);
    endproperty
    a_data: assert property (p_data) else $error("data high byte not loaded");

    property p_oe;
        oe_req ##1 !oe_req |=> !data_oe && $past(data_oe);
    endproperty
    a_oe: assert property (p_oe) else $error("data bus not released");

    property p_fail;
        s_pin_move |=> ent_q == ENT_FAIL ##1 ent_q != ENT_PROG;
    endproperty
    a_fail: assert property (p_fail) else $error("entry not refused");

    property p_lock_rise;
        (lock_q & ~$past(lock_q)) != '0 |-> $past(erase_done);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock bit cleared outside erase");

    property p_lock_prog;
        s_wr_go ##0 is_lock |=> lock_q == ($past(lock_q) & $past(data_q[7:0]));
    endproperty
    a_lock_prog: assert property (p_lock_prog) else $error("lock write wrong");

    property p_ready_idle;
        op_q == OP_IDLE ##1 op_q == OP_IDLE |-> ready_flag;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready low while idle");
endmodule // pp_prog_port
